// ==== core/hsd_pkg.sv ====
// Constants, types and carriers of the high-speed reset, suspend and chirp link controller.
package hsd_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned HSD_CLK_PERIOD_NS   = 10;
  localparam int unsigned HSD_CLKOUT_FAST_KHZ = 66000;
  localparam int unsigned HSD_T_IDLE_NS       = 3000000;
  localparam int unsigned HSD_T_REVERT_MAX_NS = 3125000;
  localparam int unsigned HSD_T_SAMPLE_NS     = 200000;
  localparam int unsigned HSD_T_FS_SE0_NS     = 2500;
  localparam int unsigned HSD_T_NOCHIRP_NS    = 2000000;
  localparam int unsigned HSD_T_RESUME_MIN_NS = 5000000;
  localparam int unsigned HSD_T_RESUME_K_NS   = 2000000;
  localparam int unsigned HSD_CHIRP_CLKOUT    = 66000;
  localparam int unsigned HSD_FILT_CLKOUT     = 165;

  function automatic int unsigned hsd_cyc_up(input longint unsigned ns);
    return int'((ns + HSD_CLK_PERIOD_NS - 1) / HSD_CLK_PERIOD_NS);
  endfunction

  // Fast-clock counts are turned into the time they last at the fastest clock.
  function automatic int unsigned hsd_fast_cyc(input longint unsigned n);
    return hsd_cyc_up((n * 1000000 + HSD_CLKOUT_FAST_KHZ - 1) / HSD_CLKOUT_FAST_KHZ);
  endfunction

  localparam int unsigned HSD_IDLE_CYC       = hsd_cyc_up(HSD_T_IDLE_NS) + 1;
  localparam int unsigned HSD_REVERT_MAX_CYC = HSD_T_REVERT_MAX_NS / HSD_CLK_PERIOD_NS;
  localparam int unsigned HSD_SAMPLE_CYC     = hsd_cyc_up(HSD_T_SAMPLE_NS);
  localparam int unsigned HSD_SE0_CYC        = hsd_cyc_up(HSD_T_FS_SE0_NS) + 1;
  localparam int unsigned HSD_NOCHIRP_CYC    = hsd_cyc_up(HSD_T_NOCHIRP_NS);
  localparam int unsigned HSD_RESUME_MIN_CYC = hsd_cyc_up(HSD_T_RESUME_MIN_NS);
  localparam int unsigned HSD_RESUME_K_CYC   = hsd_cyc_up(HSD_T_RESUME_K_NS);
  localparam int unsigned HSD_CHIRP_CYC      = hsd_fast_cyc(HSD_CHIRP_CLKOUT);
  localparam int unsigned HSD_FILT_CYC       = hsd_fast_cyc(HSD_FILT_CLKOUT);
  localparam int unsigned HSD_CNT_W          = 20;

  // ----------------------------------------------------------------
  // Pin encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] HSD_LS_SE0      = 2'h0;
  localparam logic [1:0] HSD_LS_J        = 2'h1;
  localparam logic [1:0] HSD_LS_K        = 2'h2;
  localparam logic [1:0] HSD_OP_NORMAL   = 2'h0;
  localparam logic [1:0] HSD_OP_NODRIVE  = 2'h1;
  localparam logic [1:0] HSD_OP_RAW      = 2'h2;
  localparam logic       HSD_XCVR_HS     = 1'b0;
  localparam logic       HSD_XCVR_FS     = 1'b1;
  localparam logic       HSD_TERM_HS     = 1'b0;
  localparam logic       HSD_TERM_FS     = 1'b1;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] HSD_OFS_CTRL      = 8'h00;
  localparam logic [7:0] HSD_OFS_STATUS    = 8'h04;
  localparam logic [7:0] HSD_OFS_CHIRP_LEN = 8'h08;
  localparam logic [7:0] HSD_OFS_IDLE_LEN  = 8'h0C;
  localparam int unsigned HSD_CTRL_EN_BIT  = 0;
  localparam int unsigned HSD_CTRL_RES_BIT = 1;
  localparam int unsigned HSD_ST_HS_BIT    = 4;
  localparam int unsigned HSD_EV_LSB       = 8;
  localparam int unsigned HSD_EV_W         = 4;

  typedef struct packed {
    logic       xcvrselect;
    logic       termselect;
    logic [1:0] opmode;
    logic       suspendn;
    logic       txvalid;
  } hsd_utmi_t;

  typedef enum logic [3:0] {
    ST_OFF, ST_FS, ST_HS, ST_REVERT, ST_SUSPEND, ST_RESUME, ST_CHIRP, ST_LISTEN, ST_FS_RESET
  } hsd_state_t;

endpackage

// ==== core/hsd_link_ctrl.sv ====
// Link-side sequencer for high-speed reset, suspend, resume and chirp detection.
//
// Added by the designer: register access over APB and the address map.
module hsd_link_ctrl
  import hsd_pkg::*;
#(
  parameter int unsigned IDLE_CYC       = HSD_IDLE_CYC,
  parameter int unsigned SAMPLE_CYC     = HSD_SAMPLE_CYC,
  parameter int unsigned NOCHIRP_CYC    = HSD_NOCHIRP_CYC,
  parameter int unsigned RESUME_MIN_CYC = HSD_RESUME_MIN_CYC,
  parameter int unsigned RESUME_K_CYC   = HSD_RESUME_K_CYC,
  parameter int unsigned CHIRP_CYC      = HSD_CHIRP_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [1:0]  linestate,
  output hsd_utmi_t        utmi,
  output logic      [7:0]  data_out
);

  localparam logic [HSD_CNT_W-1:0] CNT_MAX = {HSD_CNT_W{1'b1}};

  logic [1:0]           ls_meta;
  logic [1:0]           ls_sync;
  logic [1:0]           ls_q;
  logic [HSD_CNT_W-1:0] run;
  logic [HSD_CNT_W-1:0] quiet;
  logic [HSD_CNT_W-1:0] tmr;
  logic [HSD_CNT_W-1:0] chirp_len;
  logic [HSD_CNT_W-1:0] idle_len;
  hsd_state_t           state;
  hsd_state_t           next_state;
  logic [2:0]           kj_cnt;
  logic                 want_k;
  logic                 hs_mode;
  logic                 ctrl_en;
  logic                 res_pend;
  logic [HSD_EV_W-1:0]  events;
  logic [HSD_EV_W-1:0]  ev_set;
  logic                 wr_acc;

  function automatic logic [HSD_CNT_W-1:0] sat_inc(input logic [HSD_CNT_W-1:0] v);
    return (v == CNT_MAX) ? v : v + 1'b1;
  endfunction

  // True in the last cycle of an interval of len cycles counted from zero.
  function automatic logic reached(input logic [HSD_CNT_W-1:0] t,
                                   input logic [HSD_CNT_W-1:0] len);
    return ({1'b0, t} + 1'b1) >= {1'b0, len};
  endfunction

  function automatic logic [HSD_CNT_W-1:0] cnt(input int unsigned v);
    return HSD_CNT_W'(v);
  endfunction

  function automatic hsd_utmi_t drive(input hsd_state_t s);
    hsd_utmi_t u;
    u = '{xcvrselect: HSD_XCVR_FS, termselect: HSD_TERM_FS, opmode: HSD_OP_NORMAL,
          suspendn: 1'b1, txvalid: 1'b0};
    case (s)
      ST_OFF: begin
        u.opmode = HSD_OP_NODRIVE;
      end
      ST_HS: begin
        u.xcvrselect = HSD_XCVR_HS;
        u.termselect = HSD_TERM_HS;
      end
      ST_SUSPEND: begin
        u.suspendn = 1'b0;
      end
      ST_RESUME: begin
        u.opmode  = HSD_OP_RAW;
        u.txvalid = 1'b1;
      end
      ST_CHIRP: begin
        u.xcvrselect = HSD_XCVR_HS;
        u.opmode     = HSD_OP_RAW;
        u.txvalid    = 1'b1;
      end
      ST_LISTEN: begin
        u.xcvrselect = HSD_XCVR_HS;
      end
      default: begin
        u.opmode = HSD_OP_NORMAL;
      end
    endcase
    return u;
  endfunction

  // ----------------------------------------------------------------
  // Line state sampling
  // ----------------------------------------------------------------
  // The line state pins come from the transceiver clock, so they are synchronised first.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ls_meta <= HSD_LS_SE0;
      ls_sync <= HSD_LS_SE0;
    end else begin
      ls_meta <= linestate;
      ls_sync <= ls_meta;
    end
  end

  // The line state is not filtered, so the length of each steady run is counted here.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ls_q <= HSD_LS_SE0;
      run  <= '0;
    end else begin
      ls_q <= ls_sync;
      run  <= (ls_sync == ls_q) ? sat_inc(run) : cnt(1);
    end
  end

  // Squelch reads as J, so anything other than J is bus activity, chirps included.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      quiet <= '0;
    end else begin
      quiet <= (ls_q != HSD_LS_J) ? '0 : sat_inc(quiet);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tmr <= '0;
    end else begin
      tmr <= (next_state != state) ? '0 : sat_inc(tmr);
    end
  end

  // ----------------------------------------------------------------
  // Host chirp detection
  // ----------------------------------------------------------------
  // Detection runs from the own chirp onward; the own K counts as the first K, so the first host K is not counted.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      kj_cnt <= '0;
      want_k <= 1'b1;
    end else if (state != ST_CHIRP && state != ST_LISTEN) begin
      kj_cnt <= '0;
      want_k <= 1'b1;
    end else if (run == cnt(HSD_FILT_CYC) && ls_q == (want_k ? HSD_LS_K : HSD_LS_J)) begin
      kj_cnt <= (kj_cnt == 3'h4) ? kj_cnt : kj_cnt + 1'b1;
      want_k <= ~want_k;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      ST_OFF: begin
        if (ctrl_en) next_state = ST_FS;
      end
      ST_FS: begin
        if (ls_q == HSD_LS_SE0 && run >= cnt(HSD_SE0_CYC)) next_state = ST_CHIRP;
        else if (reached(quiet, idle_len)) next_state = ST_SUSPEND;
      end
      ST_HS: begin
        if (reached(quiet, idle_len)) next_state = ST_REVERT;
      end
      ST_REVERT: begin
        if (reached(tmr, cnt(SAMPLE_CYC))) begin
          if (ls_q == HSD_LS_SE0) next_state = ST_CHIRP;
          else next_state = ST_SUSPEND;
        end
      end
      ST_SUSPEND: begin
        if (ls_q == HSD_LS_SE0) next_state = ST_CHIRP;
        else if (ls_q == HSD_LS_K) next_state = hs_mode ? ST_HS : ST_FS;
        else if (res_pend && quiet >= cnt(RESUME_MIN_CYC)) next_state = ST_RESUME;
      end
      ST_RESUME: begin
        if (reached(tmr, cnt(RESUME_K_CYC))) next_state = hs_mode ? ST_HS : ST_FS;
      end
      ST_CHIRP: begin
        if (reached(tmr, chirp_len)) next_state = ST_LISTEN;
      end
      ST_LISTEN: begin
        if (kj_cnt == 3'h4) next_state = ST_HS;
        else if (reached(tmr, cnt(NOCHIRP_CYC))) next_state = ST_FS_RESET;
      end
      ST_FS_RESET: begin
        if (ls_q == HSD_LS_J && run >= cnt(HSD_FILT_CYC)) next_state = ST_FS;
      end
      default: begin
        next_state = ST_OFF;
      end
    endcase
    if (!ctrl_en) next_state = ST_OFF;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_OFF;
    end else begin
      state <= next_state;
    end
  end

  // Pins follow the next state so they change in the same edge as the state itself.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      utmi     <= drive(ST_OFF);
      data_out <= 8'h00;
    end else begin
      utmi     <= drive(next_state);
      data_out <= 8'h00;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hs_mode <= 1'b0;
    end else if (next_state == ST_HS) begin
      hs_mode <= 1'b1;
    end else if (next_state == ST_FS_RESET || next_state == ST_OFF || next_state == ST_FS) begin
      hs_mode <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  assign wr_acc = psel & penable & pready & pwrite;

  assign ev_set = {next_state == ST_FS_RESET && state != ST_FS_RESET,
                   next_state == ST_HS && state == ST_LISTEN,
                   next_state == ST_SUSPEND && state != ST_SUSPEND,
                   next_state == ST_CHIRP && state != ST_CHIRP};

  // A zero-wait slave: every access ends in its first access-phase cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
      if (psel && !penable) begin
        case (paddr)
          HSD_OFS_CTRL: begin
            prdata[HSD_CTRL_EN_BIT]  <= ctrl_en;
            prdata[HSD_CTRL_RES_BIT] <= res_pend;
          end
          HSD_OFS_STATUS: begin
            prdata[3:0]                             <= state;
            prdata[HSD_ST_HS_BIT]                   <= hs_mode;
            prdata[HSD_EV_LSB +: HSD_EV_W]          <= events;
          end
          HSD_OFS_CHIRP_LEN: begin
            prdata[HSD_CNT_W-1:0] <= chirp_len;
          end
          HSD_OFS_IDLE_LEN: begin
            prdata[HSD_CNT_W-1:0] <= idle_len;
          end
          default: begin
            pslverr <= 1'b1;
          end
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_en   <= 1'b0;
      chirp_len <= cnt(CHIRP_CYC);
      idle_len  <= cnt(IDLE_CYC);
    end else if (wr_acc) begin
      if (paddr == HSD_OFS_CTRL) ctrl_en <= pwdata[HSD_CTRL_EN_BIT];
      if (paddr == HSD_OFS_CHIRP_LEN) chirp_len <= pwdata[HSD_CNT_W-1:0];
      if (paddr == HSD_OFS_IDLE_LEN) idle_len <= pwdata[HSD_CNT_W-1:0];
    end
  end

  // A resume request waits in suspend until the quiet time allows it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      res_pend <= 1'b0;
    end else if (wr_acc && paddr == HSD_OFS_CTRL && pwdata[HSD_CTRL_RES_BIT]) begin
      res_pend <= 1'b1;
    end else if (next_state == ST_RESUME || next_state == ST_OFF) begin
      res_pend <= 1'b0;
    end
  end

  // Event flags clear on a written one; a new event in the same cycle wins.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      events <= '0;
    end else begin
      events <= (events & ~((wr_acc && paddr == HSD_OFS_STATUS) ?
                 pwdata[HSD_EV_LSB +: HSD_EV_W] : '0)) | ev_set;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  revert_time_a: assert property ((state == ST_HS && next_state == ST_REVERT)
    |-> quiet + 1'b1 >= idle_len) else $error("Reverted before the idle time.");
  revert_fs_a: assert property ((state == ST_HS && next_state == ST_REVERT)
    |=> utmi.xcvrselect == HSD_XCVR_FS && utmi.termselect == HSD_TERM_FS)
    else $error("Reversion left a high-speed setting.");
  sample_point_a: assert property ((state == ST_REVERT && next_state != ST_REVERT
    && ctrl_en) |-> tmr + 1'b1 == cnt(SAMPLE_CYC)) else $error("Line state sampled off time.");
  reset_chirp_a: assert property ((state == ST_REVERT && reached(tmr, cnt(SAMPLE_CYC))
    && ls_q == HSD_LS_SE0 && ctrl_en) |=> state == ST_CHIRP)
    else $error("SE0 sample did not start a chirp.");
  suspend_j_a: assert property ((state == ST_REVERT && reached(tmr, cnt(SAMPLE_CYC))
    && ls_q == HSD_LS_J && ctrl_en) |=> state == ST_SUSPEND && !utmi.suspendn)
    else $error("J sample did not suspend.");
  resume_wait_a: assert property ($rose(state == ST_RESUME)
    |-> $past(quiet) >= cnt(RESUME_MIN_CYC)) else $error("Resume came too early.");
  wake_chirp_a: assert property ((state == ST_SUSPEND && ls_q == HSD_LS_SE0 && ctrl_en)
    |=> state == ST_CHIRP && utmi.suspendn) else $error("Suspend SE0 not handled.");
  fs_se0_a: assert property ((state == ST_FS && next_state == ST_CHIRP)
    |-> run >= cnt(HSD_SE0_CYC) && ls_q == HSD_LS_SE0)
    else $error("Full-speed reset taken early.");
  chirp_pins_a: assert property (state == ST_CHIRP |-> utmi.opmode == HSD_OP_RAW
    && utmi.xcvrselect == HSD_XCVR_HS && utmi.txvalid && data_out == 8'h00)
    else $error("Chirp pins wrong.");
  chirp_len_a: assert property ((state == ST_CHIRP && next_state == ST_LISTEN)
    |-> tmr + 1'b1 >= chirp_len) else $error("Chirp cut short.");
  no_chirp_a: assert property ((state == ST_LISTEN && next_state == ST_FS_RESET)
    |-> tmr + 1'b1 == cnt(NOCHIRP_CYC) && kj_cnt != 3'h4)
    else $error("Fallback off time.");
  hs_entry_a: assert property ((state == ST_LISTEN && next_state == ST_HS)
    |-> kj_cnt == 3'h4 ##1 utmi.termselect == HSD_TERM_HS)
    else $error("High-speed entry without chirps.");

  hs_grant_c: cover property (state == ST_LISTEN ##1 state == ST_HS);
  fs_fallback_c: cover property (state == ST_LISTEN ##1 state == ST_FS_RESET);
  suspend_c: cover property (state == ST_REVERT ##1 state == ST_SUSPEND);
  resume_c: cover property (state == ST_SUSPEND ##1 state == ST_RESUME);

endmodule

// ==== bench/hsd_host_model.sv ====
// Upstream port and transceiver model that turns the controller's pins into line state.
module hsd_host_model
  import hsd_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire hsd_utmi_t  utmi,
  input  wire logic [7:0] data_out,
  input  wire logic       hs_capable,
  input  wire logic       host_se0,
  output logic      [1:0] linestate
);
  timeunit 1ns;
  timeprecision 1ps;

  // Each host tone lasts longer than the 250-cycle filter but well under the listen window.
  localparam int TONE = 300;

  logic chirp;
  logic chirp_q;
  int   seq;

  assign chirp = (utmi.opmode == HSD_OP_RAW) && utmi.txvalid && (utmi.xcvrselect == HSD_XCVR_HS);

  // ----------------------------------------------------------------
  // Host chirp sequence
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chirp_q <= 1'b0;
      seq     <= 0;
    end else begin
      chirp_q <= chirp;
      if (chirp_q && !chirp && host_se0 && hs_capable) begin
        seq <= 1;
      end else if (seq != 0 && seq < 6 * TONE) begin
        seq <= seq + 1;
      end else begin
        seq <= 0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Line state
  // ----------------------------------------------------------------
  always_comb begin
    if (utmi.opmode == HSD_OP_RAW && utmi.txvalid && data_out == 8'h00) begin
      linestate = HSD_LS_K;
    end else if (seq != 0) begin
      linestate = (((seq - 1) / TONE) % 2 == 1) ? HSD_LS_J : HSD_LS_K;
    end else if (!host_se0) begin
      linestate = HSD_LS_J;
    end else if (utmi.xcvrselect == HSD_XCVR_HS && utmi.termselect == HSD_TERM_HS) begin
      linestate = HSD_LS_J;
    end else begin
      linestate = HSD_LS_SE0;
    end
  end
endmodule

// ==== bench/hsd_link_ctrl_tb_top.sv ====
// Self-checking bench of the link controller against the host model.
module hsd_link_ctrl_tb_top
  import hsd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // The idle length must exceed one host tone, or a J tone would pass for an idle bus.
  localparam int IDLE_P = 500;
  localparam int CHIRP_P = 400;
  localparam int SAMPLE_P = 20;
  localparam int NOCHIRP_P = 2000;
  // Longer than idle plus sample time, so that a resume request has to wait in suspend.
  localparam int RES_MIN_P = 700;
  localparam int RES_K_P = 50;
  localparam int TONE = 300;
  localparam int FILT = 250;
  localparam int LIMIT = 20000;
  localparam hsd_utmi_t U_FS = '{HSD_XCVR_FS, HSD_TERM_FS, HSD_OP_NORMAL, 1'b1, 1'b0};
  localparam hsd_utmi_t U_CHIRP = '{HSD_XCVR_HS, HSD_TERM_FS, HSD_OP_RAW, 1'b1, 1'b1};
  localparam hsd_utmi_t U_HS = '{HSD_XCVR_HS, HSD_TERM_HS, HSD_OP_NORMAL, 1'b1, 1'b0};
  localparam hsd_utmi_t U_OFF = '{HSD_XCVR_FS, HSD_TERM_FS, HSD_OP_NODRIVE, 1'b1, 1'b0};

  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [1:0]  linestate;
  hsd_utmi_t   utmi;
  logic [7:0]  data_out;
  logic        hs_capable;
  logic        host_se0;
  int          j_run;
  int          cyc;
  int          n_errors;
  int          cmp_count;
  int          n;

  hsd_link_ctrl #(.SAMPLE_CYC(SAMPLE_P), .NOCHIRP_CYC(NOCHIRP_P), .RESUME_MIN_CYC(RES_MIN_P),
    .RESUME_K_CYC(RES_K_P)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .linestate(linestate), .utmi(utmi),
    .data_out(data_out));

  hsd_host_model host (.pclk(pclk), .presetn(presetn), .utmi(utmi), .data_out(data_out),
    .hs_capable(hs_capable), .host_se0(host_se0), .linestate(linestate));

  // ----------------------------------------------------------------
  // Clock, idle run and timeout
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    j_run <= (linestate === HSD_LS_J) ? j_run + 1 : 0;
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      n_errors++;
      results();
    end
  end

  // ----------------------------------------------------------------
  // Bus and compare tasks
  // ----------------------------------------------------------------
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_range(input int v, input int lo, input int hi);
    cmp_count++;
    if (v < lo || v > hi) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h to %h", $time, v, lo, hi);
    end
  endtask

  task automatic chk_utmi(input hsd_utmi_t exp);
    chk_word({26'h0, utmi}, {26'h0, exp});
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic exp_e);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0, q, e);
    chk_word(q, exp);
    chk_word({31'h0, e}, {31'h0, exp_e});
  endtask

  task automatic st_chk(input logic [3:0] exp);
    logic [31:0] q;
    logic        e;
    apb(1'b0, HSD_OFS_STATUS, 32'h0, q, e);
    chk_word({28'h0, q[3:0]}, {28'h0, exp});
  endtask

  // Counts edges until the chosen pin shows the wanted level: 0 txvalid, 1 xcvr, 2 term, 3 susp.
  task automatic wait_bit(input int sel, input logic v, output int cnt);
    logic b;
    cnt = 0;
    do begin
      @(posedge pclk);
      cnt++;
      b = (sel == 0) ? utmi.txvalid : (sel == 1) ? utmi.xcvrselect :
          (sel == 2) ? utmi.termselect : utmi.suspendn;
    end while (b !== v);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    rd(HSD_OFS_CTRL, 32'h0, 1'b0);
    rd(HSD_OFS_STATUS, 32'h0, 1'b0);
    rd(HSD_OFS_CHIRP_LEN, 32'h000186A0, 1'b0);
    rd(HSD_OFS_IDLE_LEN, 32'h000493E1, 1'b0);
    rd(8'h10, 32'h0, 1'b1);
    wr(HSD_OFS_IDLE_LEN, IDLE_P);
    wr(HSD_OFS_CHIRP_LEN, CHIRP_P);
    rd(HSD_OFS_IDLE_LEN, IDLE_P, 1'b0);
    $display("test regs done");
  endtask

  task automatic t_fs_hs;
    wr(HSD_OFS_CTRL, 32'h1);
    repeat (3) @(posedge pclk);
    chk_utmi(U_FS);
    host_se0 <= 1'b1;
    repeat (100) @(posedge pclk);
    host_se0 <= 1'b0;
    repeat (10) @(posedge pclk);
    st_chk(4'h1);
    host_se0 <= 1'b1;
    wait_bit(0, 1'b1, n);
    chk_range(n, 252, 258);
    chk_utmi(U_CHIRP);
    chk_word({24'h0, data_out}, 32'h0);
    wait_bit(0, 1'b0, n);
    chk_range(n, CHIRP_P - 1, CHIRP_P + 1);
    wait_bit(2, HSD_TERM_HS, n);
    // The own chirp K stands for the first K, so the host's second J completes the four.
    chk_range(n, 3 * TONE + FILT, 3 * TONE + FILT + 8);
    chk_utmi(U_HS);
    st_chk(4'h2);
    rd(HSD_OFS_STATUS, 32'h00000512, 1'b0);
    wr(HSD_OFS_STATUS, 32'h00000500);
    rd(HSD_OFS_STATUS, 32'h00000012, 1'b0);
    $display("test fs_hs done");
  endtask

  task automatic t_hs_reset;
    hs_capable <= 1'b0;
    wait_bit(1, HSD_XCVR_FS, n);
    chk_range(j_run, IDLE_P + 1, IDLE_P + 6);
    chk_word({30'h0, utmi.xcvrselect, utmi.termselect}, {30'h0, HSD_XCVR_FS, HSD_TERM_FS});
    wait_bit(0, 1'b1, n);
    chk_range(n, SAMPLE_P - 2, SAMPLE_P + 2);
    wait_bit(0, 1'b0, n);
    wait_bit(1, HSD_XCVR_FS, n);
    chk_range(n, NOCHIRP_P - 2, NOCHIRP_P + 2);
    st_chk(4'h8);
    host_se0 <= 1'b0;
    repeat (FILT + 10) @(posedge pclk);
    st_chk(4'h1);
    $display("test hs_reset done");
  endtask

  task automatic t_suspend;
    wait_bit(3, 1'b0, n);
    st_chk(4'h4);
    hs_capable <= 1'b1;
    host_se0 <= 1'b1;
    wait_bit(0, 1'b1, n);
    chk_range(n, 3, 6);
    chk_utmi(U_CHIRP);
    wait_bit(2, HSD_TERM_HS, n);
    host_se0 <= 1'b0;
    wait_bit(1, HSD_XCVR_FS, n);
    wait_bit(3, 1'b0, n);
    chk_range(n, SAMPLE_P - 2, SAMPLE_P + 3);
    st_chk(4'h4);
    wr(HSD_OFS_CTRL, 32'h3);
    wait_bit(0, 1'b1, n);
    chk_range(j_run, RES_MIN_P + 1, RES_MIN_P + 8);
    chk_word({30'h0, utmi.opmode}, {30'h0, HSD_OP_RAW});
    wait_bit(0, 1'b0, n);
    chk_range(n, RES_K_P - 1, RES_K_P + 2);
    wr(HSD_OFS_CTRL, 32'h0);
    repeat (2) @(posedge pclk);
    chk_utmi(U_OFF);
    $display("test suspend done");
  endtask

  task automatic results;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    hs_capable = 1'b1;
    host_se0 = 1'b0;
    j_run = 0;
    cyc = 0;
    n_errors = 0;
    cmp_count = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_fs_hs();
    t_hs_reset();
    t_suspend();
    results();
  end
endmodule
